//--- inc/mipwm_defines.svh
// Purpose: Constants for the interleaved phase sequencer
// Assumes: 200 MHz core clock
// Notes:   Counts are in core clock cycles
`ifndef MIPWM_DEFINES_SVH
`define MIPWM_DEFINES_SVH
`define MIPWM_CLK_MHZ        200
`define MIPWM_FSW_KHZ        1000
`define MIPWM_PERIOD_CYC     ((`MIPWM_CLK_MHZ * 1000) / `MIPWM_FSW_KHZ)
`define MIPWM_MIN_PERIOD     8
`define MIPWM_CNT_W          16
`define MIPWM_NPH            4
`define MIPWM_ISAMP_W        8
`define MIPWM_DRIVE_RST      1'b0
`define MIPWM_POWER_OK_OUT_RST      1'b0
`define MIPWM_CROWBAR_RST    1'b0
`endif

//--- inc/mipwm_pkg.sv
// Purpose: Types for the interleaved phase sequencer
// Assumes: Nothing
// Notes:   Phase count modes
package mipwm_pkg;
    typedef enum logic [1:0]
    {
        MIPWM_TWO,
        MIPWM_THREE,
        MIPWM_FOUR
    } mipwm_mode_t;
endpackage

//--- inc/mipwm_phase_if.sv
// Purpose: Signals between the sequencer and one phase channel
// Assumes: Single clock domain
// Notes:   One instance per phase
`timescale 1ns/1ps
`default_nettype none
interface mipwm_phase_if #(parameter int CNT_W = 16);
    logic             active;
    logic             term;
    logic [CNT_W-1:0] min_off;
    logic             drive;
    logic             fall;
    modport seq (output active, output term, output min_off, input drive, input fall);
    modport chan (input active, input term, input min_off, output drive, output fall);
endinterface
`default_nettype wire

//--- hw/mipwm_phase.sv
// Purpose: One phase output with forced off time and ramp set
// Assumes: Ramp crossing input already synchronised
// Notes:   Fall is a one-cycle pulse on a falling edge caused by term, not on one caused by inactive
`timescale 1ns/1ps
`default_nettype none
`include "mipwm_defines.svh"
module mipwm_phase #(
    parameter int CNT_W = `MIPWM_CNT_W
) (
    // Clock and reset
    input  wire logic  sys_clk,
    input  wire logic  rst,
    // Sequencer side
    mipwm_phase_if.chan ph,
    // Comparator
    input  wire logic  ramp_cross_in
);
    logic             drive_r;
    logic             drive_nxt;
    logic [CNT_W-1:0] off_cnt_r;
    logic [CNT_W-1:0] off_cnt_nxt;
    logic             fall_r;
    logic             fall_nxt;

    always_comb
    begin
        drive_nxt   = drive_r;
        off_cnt_nxt = off_cnt_r;
        fall_nxt    = 1'b0;
        if (!ph.active)
        begin
            drive_nxt   = 1'b0;
            off_cnt_nxt = ph.min_off;
        end
        else if (ph.term)
        begin
            fall_nxt    = drive_r;
            drive_nxt   = 1'b0;
            off_cnt_nxt = ph.min_off;
        end
        else if (off_cnt_r != '0)
        begin
            off_cnt_nxt = off_cnt_r - 1'b1;
        end
        else if (ramp_cross_in)
        begin
            drive_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            drive_r   <= `MIPWM_DRIVE_RST;
            off_cnt_r <= '0;
            fall_r    <= 1'b0;
        end
        else
        begin
            drive_r   <= drive_nxt;
            off_cnt_r <= off_cnt_nxt;
            fall_r    <= fall_nxt;
        end
    end

    assign ph.drive = drive_r;
    assign ph.fall  = fall_r;
endmodule
`default_nettype wire

//--- hw/mipwm_seq.sv
// Purpose: Multiphase interleaved pulse sequencer top
// Assumes: All inputs synchronous to sys_clk
// Notes:   Straps and period load only while disabled
`timescale 1ns/1ps
`default_nettype none
`include "mipwm_defines.svh"
module mipwm_seq #(
    parameter int CNT_W   = `MIPWM_CNT_W,
    parameter int SAMP_W  = `MIPWM_ISAMP_W,
    parameter int PERIOD  = `MIPWM_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Control
    input  wire logic              logic_enable_in,
    input  wire logic [CNT_W-1:0]  switching_freq_set,
    // Straps seen on phase three and four pins
    input  wire logic              strap3_in,
    input  wire logic              strap4_in,
    // Analog status
    input  wire logic [3:0]        ramp_cross_in,
    input  wire logic              soft_start_done_in,
    input  wire logic              undervoltage_in,
    input  wire logic              overvoltage_in,
    input  wire logic [4*SAMP_W-1:0] isense_in,
    // Outputs
    output logic                   phase1_drive_out,
    output logic                   phase2_drive_out,
    output logic                   phase3_drive_out,
    output logic                   phase4_drive_out,
    output logic                   power_ok_out,
    output logic                   overvoltage_crowbar_out,
    output logic [4*SAMP_W-1:0]    isample_out,
    output logic [2:0]             active_phases_out
);
    mipwm_pkg::mipwm_mode_t mode_r;
    mipwm_pkg::mipwm_mode_t mode_nxt;
    logic [CNT_W-1:0]       per_r;
    logic [CNT_W-1:0]       per_nxt;
    logic [CNT_W-1:0]       cnt_r;
    logic [CNT_W-1:0]       cnt_nxt;
    logic                   pok_r;
    logic                   pok_nxt;
    logic                   ovp_r;
    logic                   ovp_nxt;
    logic [2:0]             nact_r;
    logic [2:0]             nact_nxt;
    logic [3:0]             drive_w;
    logic [3:0]             fall_w;
    logic [3:0]             drive_r;
    logic [4*SAMP_W-1:0]    samp_r;
    logic [4*SAMP_W-1:0]    samp_nxt;
    logic [CNT_W-1:0]       step;
    logic [CNT_W-1:0]       third;
    logic                   run;

    assign run   = logic_enable_in && !ovp_r;
    assign third = CNT_W'(per_r / 3);

    always_comb
    begin
        case (mode_r)
            mipwm_pkg::MIPWM_TWO:   step = CNT_W'(per_r / 2);
            mipwm_pkg::MIPWM_THREE: step = third;
            mipwm_pkg::MIPWM_FOUR:  step = CNT_W'(per_r / 4);
            default:                step = CNT_W'(per_r / 4);
        endcase
    end

    // Configuration loads only while disabled
    always_comb
    begin
        mode_nxt = mode_r;
        per_nxt  = per_r;
        nact_nxt = nact_r;
        if (!logic_enable_in)
        begin
            if (switching_freq_set < CNT_W'(`MIPWM_MIN_PERIOD))
            begin
                per_nxt = CNT_W'(PERIOD);
            end
            else
            begin
                per_nxt = switching_freq_set;
            end
            if (strap3_in)
            begin
                mode_nxt = mipwm_pkg::MIPWM_TWO;
                nact_nxt = 3'd2;
            end
            else if (strap4_in)
            begin
                mode_nxt = mipwm_pkg::MIPWM_THREE;
                nact_nxt = 3'd3;
            end
            else
            begin
                mode_nxt = mipwm_pkg::MIPWM_FOUR;
                nact_nxt = 3'd4;
            end
        end
    end

    // Phase counter; count zero terminates phase one
    always_comb
    begin
        cnt_nxt = '0;
        if (run)
        begin
            if (cnt_r >= per_r - 1'b1)
            begin
                cnt_nxt = '0;
            end
            else
            begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    // Crowbar latch and power good
    always_comb
    begin
        ovp_nxt = ovp_r;
        pok_nxt = 1'b0;
        if (!logic_enable_in)
        begin
            ovp_nxt = 1'b0;
        end
        else
        begin
            if (overvoltage_in)
            begin
                ovp_nxt = 1'b1;
            end
            pok_nxt = soft_start_done_in && !undervoltage_in && !ovp_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_ph
            mipwm_phase_if #(.CNT_W(CNT_W)) pif ();
            assign pif.active  = run && (g < nact_r);
            assign pif.term    = (cnt_r == CNT_W'(g) * step);
            assign pif.min_off = third;
            assign drive_w[g]  = pif.drive;
            assign fall_w[g]   = pif.fall;
            assign samp_nxt[g*SAMP_W +: SAMP_W] = fall_w[g] ?
                isense_in[g*SAMP_W +: SAMP_W] : samp_r[g*SAMP_W +: SAMP_W];
            mipwm_phase #(.CNT_W(CNT_W)) u_ph (
                .sys_clk      (sys_clk),
                .rst          (rst),
                .ph           (pif),
                .ramp_cross_in(ramp_cross_in[g])
            );
        end
    endgenerate

    // Configuration registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mode_r <= mipwm_pkg::MIPWM_FOUR;
            per_r  <= CNT_W'(PERIOD);
            nact_r <= 3'd4;
        end
        else
        begin
            mode_r <= mode_nxt;
            per_r  <= per_nxt;
            nact_r <= nact_nxt;
        end
    end

    // Phase counter register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end

    // Fault registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pok_r <= `MIPWM_POWER_OK_OUT_RST;
            ovp_r <= `MIPWM_CROWBAR_RST;
        end
        else
        begin
            pok_r <= pok_nxt;
            ovp_r <= ovp_nxt;
        end
    end

    // Sample and output registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            samp_r  <= '0;
            drive_r <= 4'h0;
        end
        else
        begin
            samp_r  <= samp_nxt;
            drive_r <= drive_w;
        end
    end

    assign phase1_drive_out        = drive_r[0];
    assign phase2_drive_out        = drive_r[1];
    assign phase3_drive_out        = drive_r[2];
    assign phase4_drive_out        = drive_r[3];
    assign power_ok_out            = pok_r;
    assign overvoltage_crowbar_out = ovp_r;
    assign isample_out             = samp_r;
    assign active_phases_out       = nact_r;
endmodule
`default_nettype wire

//--- verif/mipwm_drv_model.sv
// Purpose: Driver and comparator stand-in for each phase
// Assumes: One core clock
// Notes:   Crossing rises a set delay after the drive falls
`timescale 1ns/1ps
`default_nettype none
module mipwm_drv_model (
    // Clock
    input  wire logic       sys_clk,
    // Sequencer side
    input  wire logic [3:0] drive_in,
    input  wire logic [7:0] delay_in,
    output logic      [3:0] ramp_cross_out
);
    logic [7:0] cnt_r [4] = '{default: 8'h00};
    initial ramp_cross_out = 4'h0;
    always @(posedge sys_clk)
        for (int g = 0; g < 4; g++)
        begin
            cnt_r[g] <= drive_in[g] ? 8'h00 : cnt_r[g] + 8'h01;
            ramp_cross_out[g] <= !drive_in[g] && cnt_r[g] >= delay_in;
        end
endmodule
`default_nettype wire

//--- verif/mipwm_seq_monitor.sv
// Purpose: Port checks for the sequencer
// Assumes: Bench period of at least 24 cycles
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module mipwm_seq_checker (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // Inputs
    input wire logic       logic_enable_in,
    input wire logic       undervoltage_in,
    input wire logic       overvoltage_in,
    // Outputs
    input wire logic       phase1_drive_out,
    input wire logic       phase2_drive_out,
    input wire logic       phase3_drive_out,
    input wire logic       phase4_drive_out,
    input wire logic       power_ok_out,
    input wire logic       overvoltage_crowbar_out,
    input wire logic [2:0] active_phases_out
);
    default clocking cb_d @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ov_sets_crowbar: assert property (logic_enable_in && overvoltage_in
        |-> ##[1:3] overvoltage_crowbar_out) else $error("crowbar not set");
    a_crowbar_latched: assert property (overvoltage_crowbar_out && logic_enable_in
        |=> overvoltage_crowbar_out) else $error("crowbar released");
    a_enable_clears: assert property (!logic_enable_in [*2]
        |=> !overvoltage_crowbar_out) else $error("crowbar kept");
    a_crowbar_quiet: assert property (overvoltage_crowbar_out [*3]
        |-> !phase1_drive_out && !phase2_drive_out && !phase3_drive_out && !phase4_drive_out)
        else $error("phase driven in crowbar");
    a_uv_drops_ok: assert property (logic_enable_in && undervoltage_in
        |-> ##[1:3] !power_ok_out) else $error("power ok kept");
    a_off_time: assert property ($fell(phase1_drive_out)
        |=> !phase1_drive_out [*7]) else $error("short off time");
    a_two_phase: assert property (active_phases_out == 3'h2
        |-> !phase3_drive_out && !phase4_drive_out) else $error("idle phase driven");
    a_three_phase: assert property (active_phases_out == 3'h3
        |-> !phase4_drive_out) else $error("phase four driven");
endmodule
bind mipwm_seq mipwm_seq_checker i_chk (.sys_clk(sys_clk), .rst(rst),
    .logic_enable_in(logic_enable_in), .undervoltage_in(undervoltage_in),
    .overvoltage_in(overvoltage_in), .phase1_drive_out(phase1_drive_out),
    .phase2_drive_out(phase2_drive_out),
    .phase3_drive_out(phase3_drive_out), .phase4_drive_out(phase4_drive_out),
    .power_ok_out(power_ok_out), .overvoltage_crowbar_out(overvoltage_crowbar_out),
    .active_phases_out(active_phases_out));
`default_nettype wire

//--- verif/mipwm_seq_bench.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Period programmed per scenario
// Notes:   Crossings come from the driver model
`timescale 1ns/1ps
`default_nettype none
`include "mipwm_defines.svh"
module mipwm_seq_bench;
    logic        sys_clk = 0, rst = 1, en = 0, s3 = 0, s4 = 0;
    logic        ss = 0, uv = 0, ov = 0, pok, cb;
    logic [31:0] isen = 0, isamp;
    logic [3:0]  rc, drv, drv_q = 0, hi = 0;
    logic [2:0]  act;
    logic [7:0]  dly = 0;
    logic [15:0] fs = 16'h0018;
    int          mismatches = 0, checked = 0, cyc = 0, lf[4];
    int unsigned seed = 57;
    always #2.5 sys_clk = ~sys_clk;
    mipwm_seq i_dut (.sys_clk(sys_clk), .rst(rst), .logic_enable_in(en),
        .switching_freq_set(fs), .strap3_in(s3), .strap4_in(s4),
        .ramp_cross_in(rc), .soft_start_done_in(ss), .undervoltage_in(uv),
        .overvoltage_in(ov), .isense_in(isen), .phase1_drive_out(drv[0]),
        .phase2_drive_out(drv[1]), .phase3_drive_out(drv[2]),
        .phase4_drive_out(drv[3]), .power_ok_out(pok), .overvoltage_crowbar_out(cb),
        .isample_out(isamp), .active_phases_out(act));
    mipwm_drv_model i_drv (.sys_clk(sys_clk), .drive_in(drv), .delay_in(dly),
        .ramp_cross_out(rc));
    // Last falling edge and any high level per phase
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        drv_q <= drv;
        for (int g = 0; g < 4; g++)
        begin
            if (drv_q[g] && !drv[g])
                lf[g] = cyc;
            hi[g] = hi[g] | drv[g];
        end
    end
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Strap three wins over strap four
    function automatic int exp_phases(input bit s3_v, input bit s4_v);
        return s3_v ? 2 : (s4_v ? 3 : 4);
    endfunction
    // Too short a setting falls back to the default period
    function automatic int exp_period(input int p);
        return (p < `MIPWM_MIN_PERIOD) ? `MIPWM_PERIOD_CYC : p;
    endfunction
    task automatic look();
        @(negedge sys_clk);
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok)
        begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic run_mode(input int i, input int p);
        int n;
        int ep;
        int d;
        en <= 1'b0;
        tk(4);
        s3 <= i[1];
        s4 <= i[0];
        fs <= 16'(p);
        isen <= xs();
        dly <= 8'(xs() % 12);
        hi = 4'h0;
        n = exp_phases(i[1], i[0]);
        ep = exp_period(p);
        tk(3);
        en <= 1'b1;
        tk(2);
        s3 <= ~s3;
        fs <= 16'h0009;
        tk(3 * ep + 80);
        look();
        chk(act === 3'(n), "phase count");
        for (int g = 0; g < 4; g++)
        begin
            d = ((lf[g] - lf[0]) % ep + ep) % ep;
            if (g < n)
            begin
                chk(hi[g] === 1'b1 && d == g * (ep / n), "spacing");
                chk(isamp[g*8+:8] === isen[g*8+:8], "sample");
            end
            else
            begin
                chk(hi[g] === 1'b0, "idle phase");
            end
        end
        tk(1);
        s3 <= i[1];
    endtask
    initial
    begin
        tk(2);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            run_mode(i, 24);
        run_mode(0, 3);
        look();
        chk(pok === 1'b0, "early ok");
        tk(1);
        ss <= 1'b1;
        tk(4);
        look();
        chk(pok === 1'b1, "ok after start");
        tk(1);
        uv <= 1'b1;
        tk(4);
        look();
        chk(pok === 1'b0, "undervoltage");
        tk(1);
        uv <= 1'b0;
        ov <= 1'b1;
        tk(1);
        ov <= 1'b0;
        tk(30);
        look();
        chk(cb === 1'b1 && drv === 4'h0, "crowbar");
        tk(1);
        en <= 1'b0;
        tk(4);
        look();
        chk(cb === 1'b0 && pok === 1'b0, "cleared");
        stop_test();
    end
endmodule
`default_nettype wire
